// File: common/otp_host_pkg.sv
package otp_host_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ      = 20;
  localparam int RST_LOW_US   = 480;
  localparam int RECOV_US     = 480;
  localparam int PULSE_US     = 2500;
  localparam int PRES_LO_US   = 15;
  localparam int PRES_HI_US   = 240;
  localparam int SLOT_US      = 70;
  localparam int STRB_US      = 5;
  localparam int W0_US        = 60;
  localparam int SAMPLE_US    = 13;
  // reset low must exceed its figure, so one extra cycle
  localparam int RST_CYC_DEF   = RST_LOW_US * CLK_MHZ + 1;
  localparam int RECOV_CYC_DEF = RECOV_US * CLK_MHZ;
  localparam int PULSE_CYC_DEF = PULSE_US * CLK_MHZ;
  localparam logic [15:0] PRES_LO_CYC = 16'(PRES_LO_US * CLK_MHZ);
  localparam logic [15:0] PRES_HI_CYC = 16'(PRES_HI_US * CLK_MHZ);
  localparam logic [15:0] SLOT_CYC    = 16'(SLOT_US * CLK_MHZ);
  localparam logic [15:0] STRB_CYC    = 16'(STRB_US * CLK_MHZ);
  localparam logic [15:0] W0_CYC      = 16'(W0_US * CLK_MHZ);
  localparam logic [15:0] SAMPLE_CYC  = 16'(SAMPLE_US * CLK_MHZ);
  localparam logic [1:0]  MAX_TRIES   = 2'h3;

  // ----------------------------------------------------------------------
  // opcodes and crc
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_SKIP_ROM = 8'hcc;
  localparam logic [7:0] OP_WR_MEM   = 8'h0f;
  localparam logic [7:0] OP_RD_STAT  = 8'haa;
  localparam logic [7:0] OP_WR_STAT  = 8'h55;
  localparam logic [7:0] OP_PROG     = 8'h5a;
  localparam logic [7:0] ADDR_HI     = 8'h00;
  localparam logic [7:0] RX_FILL     = 8'hff;
  localparam logic [7:0] CRC_POLY_R  = 8'h8c;
  localparam logic [7:0] CRC_INIT    = 8'h00;

  // ----------------------------------------------------------------------
  // result codes and types
  // ----------------------------------------------------------------------
  localparam logic [2:0] ERR_NONE    = 3'h0;
  localparam logic [2:0] ERR_NO_PRES = 3'h1;
  localparam logic [2:0] ERR_CRC     = 3'h2;
  localparam logic [2:0] ERR_VERIFY  = 3'h3;
  localparam logic [2:0] ERR_ABORT   = 3'h4;

  typedef enum logic [1:0] {
    CMD_WR_MEM  = 2'h0,
    CMD_RD_STAT = 2'h1,
    CMD_WR_STAT = 2'h2
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RESET  = 4'h1,
    ST_PRES   = 4'h3,
    ST_SKIP   = 4'h2,
    ST_CMD    = 4'h6,
    ST_ALO    = 4'h7,
    ST_AHI    = 4'h5,
    ST_HCRC   = 4'h4,
    ST_DATA   = 4'hc,
    ST_DCRC   = 4'hd,
    ST_PROG   = 4'hf,
    ST_PULSE  = 4'he,
    ST_VERIFY = 4'ha,
    ST_SREAD  = 4'hb,
    ST_SCRC   = 4'h9
  } step_t;

  // one crc bit, lsb-first shift
  function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc8_bit = fb ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
  endfunction

endpackage

// File: hw/otp_host.sv
// Function
// - send skip, 0Fh, address low, high
// - send eight data bytes, check crc
// - send 5Ah then hold programming voltage
// - memory start address is multiple of eight
// - abort by reset, never during pulse
// - crc mismatch gives reset and full retry, three tries at most
// - send skip, AAh, address, check crc
// - send 55h, address, data byte lsb first
// - on good crc send 5Ah and pulse
// - eight read slots verify status byte
// - crc polynomial x8+x5+x4+1
// - reset low over 480us, expect presence
// - skip rom precedes every function opcode
`timescale 1ns/1ps
module otp_host
  import otp_host_pkg::*;
#(
  parameter int RST_CYC   = RST_CYC_DEF,
  parameter int RECOV_CYC = RECOV_CYC_DEF,
  parameter int PULSE_CYC = PULSE_CYC_DEF,
  parameter int TDIV      = 1
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               start_in,
  input  wire logic               abort_in,
  input  wire otp_host_pkg::cmd_t cmd_in,
  input  wire logic [6:0]         addr_in,
  input  wire logic [63:0]        data_in,
  input  wire logic [2:0]         count_in,
  input  wire logic               dq_in,
  output logic                    dq_out,
  output logic                    dq_oe_out,
  output logic                    vpp_en_out,
  output logic                    busy_out,
  output logic                    done_out,
  output logic [2:0]              err_out,
  output logic [63:0]             status_out
);
  import otp_host_pkg::*;

  // slot timing, divisible for short runs
  localparam logic [15:0] SLOT_N    = 16'(SLOT_CYC / TDIV);
  localparam logic [15:0] STRB_N    = 16'(STRB_CYC / TDIV);
  localparam logic [15:0] W0_N      = 16'(W0_CYC / TDIV);
  localparam logic [15:0] SAMPLE_N  = 16'(SAMPLE_CYC / TDIV);
  localparam logic [15:0] PRES_LO_N = 16'(PRES_LO_CYC / TDIV);
  localparam logic [15:0] PRES_HI_N = 16'(PRES_HI_CYC / TDIV);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  step_t       step_q, step_d;
  cmd_t        cmd_q;
  logic [6:0]  addr_q;
  logic [63:0] data_q;
  logic [2:0]  cnt_q;
  logic [15:0] tmr_q, tmr_d;
  logic [2:0]  bit_q, idx_q, idx_d, sa_q, sa_d;
  logic [7:0]  sh_q, crc_q, crc_d, tx_nx;
  logic [1:0]  try_q, try_d;
  logic [2:0]  err_d;
  logic        s1_q, s2_q, s3_q, line_q, samp_q, pres_q, abort_q;
  logic        fin, fail, crc_ld;
  logic [2:0]  fail_code;
  logic [7:0]  crc_seed;

  function automatic logic is_byte(input step_t s);
    is_byte = !(s inside {ST_IDLE, ST_RESET, ST_PRES, ST_PULSE});
  endfunction

  function automatic logic is_tx(input step_t s);
    is_tx = s inside {ST_SKIP, ST_CMD, ST_ALO, ST_AHI, ST_DATA, ST_PROG};
  endfunction

  // ----------------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------------
  wire        in_byte   = is_byte(step_q);
  wire        tx_now    = is_tx(step_q);
  wire        slot_end  = in_byte && (tmr_q == SLOT_N - 16'h1);
  wire        byte_end  = slot_end && (bit_q == 3'h7);
  wire        bitv      = tx_now ? sh_q[0] : samp_q;
  wire [15:0] low_len   = (tx_now && !sh_q[0]) ? W0_N : STRB_N;
  wire        oe_d      = (step_q == ST_RESET) || (in_byte && (tmr_q < low_len));
  wire [7:0]  crc_nx    = crc8_bit(crc_q, bitv);
  wire        crc_ok    = (crc_nx == CRC_INIT);
  wire [7:0]  rxb       = {bitv, sh_q[7:1]};
  wire [7:0]  dbyte     = data_q[{idx_q, 3'h0} +: 8];
  wire        verify_ok = ((rxb & ~dbyte) == 8'h00);
  wire        rst_done  = (tmr_q == 16'(RST_CYC - 1));
  wire        rec_done  = (tmr_q == 16'(RECOV_CYC - 1));
  wire        pls_done  = (tmr_q == 16'(PULSE_CYC - 1));
  wire        in_pwin   = (tmr_q >= PRES_LO_N) && (tmr_q <= PRES_HI_N);
  wire [7:0]  mem_lo    = {1'b0, addr_q[6:3], 3'h0};
  wire [2:0]  sa_start  = (step_q == ST_IDLE) ? addr_in[2:0] : addr_q[2:0];
  wire [7:0]  op_byte   = (cmd_q == CMD_WR_MEM)  ? OP_WR_MEM :
                          (cmd_q == CMD_RD_STAT) ? OP_RD_STAT : OP_WR_STAT;
  wire        wstat     = (cmd_q == CMD_WR_STAT);

  // next transmit byte, chosen by the step being entered
  always_comb begin
    unique case (step_d)
      ST_SKIP: tx_nx = OP_SKIP_ROM;
      ST_CMD:  tx_nx = (step_q == ST_IDLE) ? RX_FILL : op_byte;
      ST_ALO:  tx_nx = wstat || (cmd_q == CMD_RD_STAT) ? {5'h00, sa_q} : mem_lo;
      ST_AHI:  tx_nx = ADDR_HI;
      ST_DATA: tx_nx = data_q[{idx_d, 3'h0} +: 8];
      ST_PROG: tx_nx = OP_PROG;
      default: tx_nx = RX_FILL;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    step_d    = step_q;
    idx_d     = idx_q;
    sa_d      = sa_q;
    try_d     = try_q;
    err_d     = err_out;
    crc_ld    = 1'b0;
    crc_seed  = CRC_INIT;
    fin       = 1'b0;
    fail      = 1'b0;
    fail_code = ERR_CRC;
    unique case (step_q)
      ST_IDLE: begin
        if (start_in) begin
          step_d = ST_RESET;
          try_d  = 2'h0;
          err_d  = ERR_NONE;
        end
      end
      ST_RESET: if (rst_done) step_d = ST_PRES;
      ST_PRES: begin
        if (rec_done) begin
          if (abort_q) begin
            fin   = 1'b1;
            err_d = ERR_ABORT;
          end else if (!pres_q) begin
            fin   = 1'b1;
            err_d = ERR_NO_PRES;
          end else begin
            step_d = ST_SKIP;
          end
        end
      end
      ST_SKIP: if (byte_end) step_d = ST_CMD;
      ST_CMD: begin
        if (byte_end) step_d = ST_ALO;
      end
      ST_ALO: if (byte_end) step_d = ST_AHI;
      ST_AHI: if (byte_end) step_d = wstat ? ST_DATA : ST_HCRC;
      ST_HCRC: begin
        if (byte_end) begin
          if (!crc_ok) begin
            fail = 1'b1;
          end else begin
            crc_ld = 1'b1;
            step_d = (cmd_q == CMD_RD_STAT) ? ST_SREAD : ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (byte_end) begin
          if (!wstat && (idx_q != 3'h7)) begin
            idx_d = idx_q + 3'h1;
          end else begin
            step_d = ST_DCRC;
          end
        end
      end
      ST_DCRC: begin
        if (byte_end) begin
          if (crc_ok) step_d = ST_PROG;
          else fail = 1'b1;
        end
      end
      ST_PROG: if (byte_end) step_d = ST_PULSE;
      ST_PULSE: begin
        if (pls_done) begin
          step_d = ST_VERIFY;
          idx_d  = wstat ? idx_q : 3'h0;
        end
      end
      ST_VERIFY: begin
        if (byte_end) begin
          if (!verify_ok) begin
            fail      = 1'b1;
            fail_code = ERR_VERIFY;
          end else if (!wstat && (idx_q != 3'h7)) begin
            idx_d = idx_q + 3'h1;
          end else if (!wstat || (idx_q == cnt_q) || (sa_q == 3'h7)) begin
            fin = 1'b1;
          end else begin
            idx_d    = idx_q + 3'h1;
            sa_d     = sa_q + 3'h1;
            crc_ld   = 1'b1;
            crc_seed = {5'h00, sa_d};
            step_d   = ST_DATA;
          end
        end
      end
      ST_SREAD: begin
        if (byte_end) begin
          if (sa_q == 3'h7) step_d = ST_SCRC;
          else sa_d = sa_q + 3'h1;
        end
      end
      ST_SCRC: begin
        if (byte_end) begin
          if (crc_ok) fin = 1'b1;
          else fail = 1'b1;
        end
      end
      default: step_d = ST_IDLE;
    endcase
    if (fail) begin
      if (try_q == MAX_TRIES - 2'h1) begin
        fin   = 1'b1;
        err_d = fail_code;
      end else begin
        try_d  = try_q + 2'h1;
        step_d = ST_RESET;
      end
    end
    if (abort_q && !(step_q inside {ST_IDLE, ST_RESET, ST_PRES, ST_PULSE})) begin
      step_d = ST_RESET;
      fin    = 1'b0;
    end
    if (fin) step_d = ST_IDLE;
    if ((step_d == ST_RESET) && (step_q != ST_RESET)) begin
      idx_d = 3'h0;
      sa_d  = sa_start;
    end
    if ((step_d == ST_CMD) && (step_q != ST_CMD)) crc_ld = 1'b1;
  end

  wire restart = (step_d != step_q) || slot_end;
  assign tmr_d = restart ? 16'h0000 : tmr_q + 16'h0001;
  assign crc_d = crc_ld ? crc_seed : (slot_end ? crc_nx : crc_q);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      line_q <= 1'b1;
    end else begin
      s1_q   <= dq_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      line_q <= (s2_q == s3_q) ? s2_q : line_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_q <= ST_IDLE;
      tmr_q  <= 16'h0000;
      bit_q  <= 3'h0;
      idx_q  <= 3'h0;
      sa_q   <= 3'h0;
      try_q  <= 2'h0;
      sh_q   <= RX_FILL;
      crc_q  <= CRC_INIT;
      samp_q <= 1'b1;
    end else begin
      step_q <= step_d;
      tmr_q  <= tmr_d;
      bit_q  <= (step_d != step_q) ? 3'h0 : (slot_end ? bit_q + 3'h1 : bit_q);
      idx_q  <= idx_d;
      sa_q   <= sa_d;
      try_q  <= try_d;
      sh_q   <= ((step_d != step_q) || byte_end) ? tx_nx : (slot_end ? rxb : sh_q);
      crc_q  <= crc_d;
      samp_q <= (tmr_q == SAMPLE_N) ? line_q : samp_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_q   <= CMD_WR_MEM;
      addr_q  <= 7'h00;
      data_q  <= 64'h0;
      cnt_q   <= 3'h0;
      pres_q  <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      if ((step_q == ST_IDLE) && start_in) begin
        cmd_q  <= cmd_in;
        addr_q <= addr_in;
        data_q <= data_in;
        cnt_q  <= count_in;
      end
      pres_q  <= (step_q == ST_RESET) ? 1'b0 :
                 (((step_q == ST_PRES) && in_pwin && !line_q) ? 1'b1 : pres_q);
      abort_q <= (step_q == ST_IDLE) ? 1'b0 : (abort_q || abort_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_out     <= 1'b0;
      dq_oe_out  <= 1'b0;
      vpp_en_out <= 1'b0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      err_out    <= ERR_NONE;
      status_out <= 64'h0;
    end else begin
      dq_out     <= 1'b0;
      dq_oe_out  <= oe_d;
      vpp_en_out <= (step_q == ST_PULSE);
      busy_out   <= (step_d != ST_IDLE);
      done_out   <= fin;
      err_out    <= err_d;
      if ((step_q == ST_SREAD) && byte_end) status_out[{sa_q, 3'h0} +: 8] <= rxb;
    end
  end

endmodule

// File: verification/otp_host_assertions.sv
`timescale 1ns/1ps
module otp_host_assertions
  import otp_host_pkg::*;
#(
  parameter int RST_CYC   = RST_CYC_DEF,
  parameter int RECOV_CYC = RECOV_CYC_DEF,
  parameter int PULSE_CYC = PULSE_CYC_DEF,
  parameter int TDIV      = 1
) (
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic               start_in,
  input wire logic               abort_in,
  input wire otp_host_pkg::cmd_t cmd_in,
  input wire logic [6:0]         addr_in,
  input wire logic [63:0]        data_in,
  input wire logic [2:0]         count_in,
  input wire logic               dq_in,
  input wire logic               dq_out,
  input wire logic               dq_oe_out,
  input wire logic               vpp_en_out,
  input wire logic               busy_out,
  input wire logic               done_out,
  input wire logic [2:0]         err_out,
  input wire logic [63:0]        status_out
);
  // ----
  // length counters
  // ----
  logic [15:0] vpp_cnt_q;
  logic [15:0] low_cnt_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vpp_cnt_q <= 16'h0;
      low_cnt_q <= 16'h0;
    end else begin
      vpp_cnt_q <= vpp_en_out ? vpp_cnt_q + 16'h1 : 16'h0;
      low_cnt_q <= dq_oe_out ? low_cnt_q + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_vpp_excl; vpp_en_out |-> !dq_oe_out; endproperty
  a_vpp_excl: assert property (p_vpp_excl)
    else $error("line pulled low during program pulse");
  property p_pulse_len; $fell(vpp_en_out) |-> vpp_cnt_q >= PULSE_CYC; endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("program pulse too short");
  property p_pulse_entry; $rose(vpp_en_out) |-> !$past(dq_oe_out) && busy_out; endproperty
  a_pulse_entry: assert property (p_pulse_entry)
    else $error("program pulse from a low line or while idle");
  property p_low_len;
    $fell(dq_oe_out) |-> low_cnt_q >= RST_CYC ||
      (low_cnt_q >= 16'(STRB_CYC / TDIV) && low_cnt_q <= 16'(W0_CYC / TDIV));
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("line low time fits neither slot nor reset");
  property p_start; start_in && !busy_out |=> busy_out ##1 dq_oe_out; endproperty
  a_start: assert property (p_start)
    else $error("command did not open with a reset");
  property p_end; $fell(busy_out) |-> done_out && !dq_oe_out && !vpp_en_out; endproperty
  a_end: assert property (p_end)
    else $error("command ended without done or with line held");
  property p_done; done_out |=> !done_out ##1 !done_out; endproperty
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  property p_idle;
    !busy_out && !start_in |=> $stable(err_out) && $stable(status_out) && !dq_oe_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("outputs moved while idle");
endmodule
bind otp_host otp_host_assertions #(
  .RST_CYC(RST_CYC), .RECOV_CYC(RECOV_CYC), .PULSE_CYC(PULSE_CYC), .TDIV(TDIV)
) otp_host_assertions_inst (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .abort_in(abort_in),
  .cmd_in(cmd_in), .addr_in(addr_in), .data_in(data_in), .count_in(count_in),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .vpp_en_out(vpp_en_out),
  .busy_out(busy_out), .done_out(done_out), .err_out(err_out), .status_out(status_out)
);

// File: verification/otp_dev_model.sv
`timescale 1ns/1ps
module otp_dev_model (
  input  wire logic dq_in,
  input  wire logic vpp_in,
  output logic      pull_out
);
  // ----
  // device memories and link
  // ----
  logic [7:0] mem [0:127];
  logic [7:0] stat [0:7];
  logic [7:0] ram [0:7];
  logic       present;
  int         bad_crc;
  event       rst_ev;
  realtime    t_fall;
  initial begin
    pull_out = 0;
    present = 1;
    bad_crc = 0;
    for (int i = 0; i < 128; i++) mem[i] = 8'hff;
    for (int i = 0; i < 8; i++) stat[i] = (i == 7) ? 8'h00 : 8'hff;
  end
  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
  task automatic rx(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge dq_in);
      #3000 d[i] = dq_in;
    end
  endtask
  task automatic tx(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge dq_in);
      pull_out = !d[i];
      #3000 pull_out = 0;
    end
  endtask
  task automatic session();
    logic [7:0] op, lo, hi, d, c;
    int a;
    rx(op);
    if (op !== 8'hcc) wait (0);
    rx(op);
    rx(lo);
    rx(hi);
    if (op == 8'h55) rx(d);
    c = crc_upd(crc_upd(crc_upd(8'h00, op), lo), hi);
    if (op == 8'h55) c = crc_upd(c, d);
    if (bad_crc > 0) c = ~c;
    if (bad_crc > 0) bad_crc--;
    tx(c);
    a = {hi, lo};
    case (op)
      8'h0f: begin
        c = 8'h00;
        for (int i = 0; i < 8; i++) begin
          rx(ram[i]);
          c = crc_upd(c, ram[i]);
        end
        tx(c);
        rx(d);
        @(posedge vpp_in);
        if (d == 8'h5a) for (int i = 0; i < 8; i++) mem[(a + i) % 128] &= ram[i];
        forever begin
          tx(mem[a % 128]);
          a++;
        end
      end
      8'haa: begin
        c = 8'h00;
        while (a < 8) begin
          tx(stat[a]);
          c = crc_upd(c, stat[a]);
          a++;
        end
        tx(c);
        forever tx(8'hff);
      end
      8'h55: forever begin
        rx(op);
        @(posedge vpp_in);
        if (op == 8'h5a) stat[a % 8] &= d;
        tx(stat[a % 8]);
        a++;
        rx(d);
        tx(crc_upd(8'(a), d));
      end
      default: wait (0);
    endcase
  endtask
  always begin
    @(negedge dq_in);
    t_fall = $realtime;
    @(posedge dq_in);
    if ($realtime - t_fall > 8000) -> rst_ev;
  end
  initial begin
    @rst_ev;
    forever begin
      fork
        if (present) begin
          #2000 pull_out = 1;
          #6000 pull_out = 0;
          session();
        end
      join_none
      @rst_ev;
      disable fork;
      pull_out = 0;
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected %s exp %0h got %0h", what, exp, got); \
    end \
  end
module tb;
  import otp_host_pkg::*;
  logic        sys_clk_in, rst_n_in, start_in, abort_in;
  cmd_t        cmd_in;
  logic [6:0]  addr_in;
  logic [63:0] data_in, status_out;
  logic [2:0]  count_in, err_out;
  logic        dq_out, dq_oe_out, vpp_en_out, busy_out, done_out, dev_pull;
  int          n_mismatch, tests_run;
  wire logic   dq_line;
  // ----
  // open-drain line with pull-up
  // ----
  assign dq_line = !((dq_oe_out && !dq_out) || dev_pull);
  always #25 sys_clk_in = ~sys_clk_in;
  otp_host #(.RST_CYC(200), .RECOV_CYC(490), .PULSE_CYC(100), .TDIV(10)) otp_host_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .abort_in(abort_in),
    .cmd_in(cmd_in), .addr_in(addr_in), .data_in(data_in), .count_in(count_in),
    .dq_in(dq_line), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .vpp_en_out(vpp_en_out),
    .busy_out(busy_out), .done_out(done_out), .err_out(err_out), .status_out(status_out)
  );
  otp_dev_model otp_dev_model_inst (.dq_in(dq_line), .vpp_in(vpp_en_out), .pull_out(dev_pull));
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input cmd_t c, input logic [6:0] a, input logic [63:0] d,
                     input logic [2:0] n, input int ab);
    int i;
    @(negedge sys_clk_in);
    cmd_in = c;
    addr_in = a;
    data_in = d;
    count_in = n;
    start_in = 1;
    @(negedge sys_clk_in);
    start_in = 0;
    if (ab > 0) begin
      repeat (ab) @(negedge sys_clk_in);
      abort_in = 1;
      @(negedge sys_clk_in);
      abort_in = 0;
    end
    for (i = 0; i < 40000 && done_out !== 1'b1; i++) @(negedge sys_clk_in);
    `CHK("done", 1'b1, done_out)
  endtask
  task automatic t_no_presence();
    otp_dev_model_inst.present = 0;
    run(CMD_RD_STAT, 7'h5, 64'h0, 3'h0, 0);
    `CHK("err", ERR_NO_PRES, err_out)
    otp_dev_model_inst.present = 1;
  endtask
  task automatic t_abort();
    run(CMD_RD_STAT, 7'h5, 64'h0, 3'h0, 2000);
    `CHK("err", ERR_ABORT, err_out)
  endtask
  task automatic t_crc_fail();
    otp_dev_model_inst.bad_crc = 3;
    run(CMD_RD_STAT, 7'h7, 64'h0, 3'h0, 0);
    `CHK("err", ERR_CRC, err_out)
  endtask
  task automatic t_wr_status();
    run(CMD_WR_STAT, 7'h6, 64'h3ca5, 3'h1, 0);
    `CHK("err", ERR_NONE, err_out)
    `CHK("stat6", 8'ha5, otp_dev_model_inst.stat[6])
    `CHK("stat7", 8'h00, otp_dev_model_inst.stat[7])
  endtask
  task automatic t_rd_status();
    otp_dev_model_inst.bad_crc = 1;
    run(CMD_RD_STAT, 7'h5, 64'h0, 3'h0, 0);
    `CHK("err", ERR_NONE, err_out)
    `CHK("low bytes", 40'h0, status_out[39:0])
    `CHK("byte5", 8'hff, status_out[47:40])
    `CHK("byte6", 8'ha5, status_out[55:48])
    `CHK("byte7", 8'h00, status_out[63:56])
  endtask
  task automatic t_wr_mem();
    logic [63:0] d;
    d = 64'h0123456789abcdef;
    for (int i = 8; i < 16; i++) otp_dev_model_inst.mem[i] = 8'hf0;
    run(CMD_WR_MEM, 7'h0b, d, 3'h0, 0);
    `CHK("err", ERR_NONE, err_out)
    for (int i = 0; i < 8; i++) `CHK("seg", 8'hf0 & d[8*i+:8], otp_dev_model_inst.mem[8+i])
    `CHK("next seg", 8'hff, otp_dev_model_inst.mem[16])
  endtask
  initial begin
    sys_clk_in = 0;
    rst_n_in = 0;
    start_in = 0;
    abort_in = 0;
    cmd_in = CMD_WR_MEM;
    addr_in = 7'h0;
    data_in = 64'h0;
    count_in = 3'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1;
    t_no_presence();
    t_abort();
    t_crc_fail();
    t_wr_status();
    t_rd_status();
    t_wr_mem();
    stop_test();
  end
  initial begin
    repeat (95000) @(posedge sys_clk_in);
    n_mismatch++;
    stop_test();
  end
endmodule
